// File: lfcb_cfg.svh
// offsets, field positions, reset values and scale figures of the coefficient bank
`ifndef LFCB_CFG_SVH
`define LFCB_CFG_SVH

// ----------------------------------------
// register indexes (byte address = 4 x index)
// ----------------------------------------
`define LFCB_IDX_CHB_NRM_HF   16'hFE33
`define LFCB_IDX_CHA_LL_LF    16'hFE34
`define LFCB_IDX_CHB_LL_LF    16'hFE35
`define LFCB_IDX_CHA_LL_ZERO  16'hFE36
`define LFCB_IDX_CHB_LL_ZERO  16'hFE37
`define LFCB_IDX_CHA_LL_POLE  16'hFE38
`define LFCB_IDX_CHB_LL_POLE  16'hFE39
`define LFCB_IDX_CHA_LL_HF    16'hFE3A
`define LFCB_IDX_CHB_LL_HF    16'hFE3B
`define LFCB_IDX_CHA_MODLIM   16'hFE3C
`define LFCB_IDX_CHB_MODLIM   16'hFE3D

// ----------------------------------------
// bus layout
// ----------------------------------------
`define LFCB_ADDR_W           18
`define LFCB_IDX_MSB          17
`define LFCB_IDX_LSB          2
`define LFCB_COEF_MSB         7
`define LFCB_RD_PAD_W         24

// ----------------------------------------
// reset values
// ----------------------------------------
`define LFCB_RST_COEF         8'h00
`define LFCB_RST_MODLIM       8'h00
`define LFCB_RST_RDATA        32'h0000_0000

// ----------------------------------------
// gain scale, in milli-dB
// ----------------------------------------
`define LFCB_GAIN_STEP_MDB    300
`define LFCB_GAIN_SPAN_MDB    20000

`endif

// File: lfcb_pkg.sv
// types shared by the coefficient bank modules
package lfcb_pkg;

    // ----------------------------------------
    // scalar types
    // ----------------------------------------
    typedef logic [7:0]  lfcb_coef_t;
    typedef logic [31:0] lfcb_word_t;
    typedef logic [17:0] lfcb_addr_t;

    // ----------------------------------------
    // bus slave states
    // ----------------------------------------
    typedef enum logic [1:0] {
        LFCB_ST_IDLE   = 2'b01,
        LFCB_ST_ACCESS = 2'b10
    } lfcb_bus_st_t;

    // ----------------------------------------
    // register file and module state
    // ----------------------------------------
    typedef struct packed {
        lfcb_coef_t chb_nrm_hf;
        lfcb_coef_t cha_ll_lf;
        lfcb_coef_t chb_ll_lf;
        lfcb_coef_t cha_ll_zero;
        lfcb_coef_t chb_ll_zero;
        lfcb_coef_t cha_ll_pole;
        lfcb_coef_t chb_ll_pole;
        lfcb_coef_t cha_ll_hf;
        lfcb_coef_t chb_ll_hf;
        lfcb_coef_t cha_modlim;
        lfcb_coef_t chb_modlim;
    } lfcb_regs_t;

    typedef struct packed {
        lfcb_bus_st_t st;
        lfcb_regs_t   regs;
        lfcb_word_t   prdata;
        logic         pslverr;
    } lfcb_bank_t;

    typedef struct packed {
        lfcb_coef_t lf;
        lfcb_coef_t zero;
        lfcb_coef_t pole;
        lfcb_coef_t hf;
    } lfcb_coef_set_t;

endpackage : lfcb_pkg

// File: lfcb_coef_sel.sv
// per-channel choice between normal and light-load coefficient sets
module lfcb_coef_sel (
    input  wire logic           clk,
    input  wire logic           resetn,
    input  wire logic           light_mode,
    input  wire lfcb_pkg::lfcb_coef_t nrm_lf,
    input  wire lfcb_pkg::lfcb_coef_t nrm_zero,
    input  wire lfcb_pkg::lfcb_coef_t nrm_pole,
    input  wire lfcb_pkg::lfcb_coef_t nrm_hf,
    input  wire lfcb_pkg::lfcb_coef_t ll_lf,
    input  wire lfcb_pkg::lfcb_coef_t ll_zero,
    input  wire lfcb_pkg::lfcb_coef_t ll_pole,
    input  wire lfcb_pkg::lfcb_coef_t ll_hf,
    output lfcb_pkg::lfcb_coef_t      lf_gain,
    output lfcb_pkg::lfcb_coef_t      zero_pos,
    output lfcb_pkg::lfcb_coef_t      pole_pos,
    output lfcb_pkg::lfcb_coef_t      hf_gain
);
    import lfcb_pkg::*;
    `include "lfcb_cfg.svh"

    lfcb_coef_set_t cur_reg;
    lfcb_coef_set_t cur_next;

    // ----------------------------------------
    // set selection
    // ----------------------------------------
    // registered so the filter never sees a half-switched set
    always_comb begin
        cur_next = cur_reg;
        if (light_mode) begin
            cur_next = '{lf: ll_lf, zero: ll_zero, pole: ll_pole, hf: ll_hf}; // [R07]
        end else begin
            cur_next = '{lf: nrm_lf, zero: nrm_zero, pole: nrm_pole, hf: nrm_hf}; // [R07]
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cur_reg <= {4{`LFCB_RST_COEF}};
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign lf_gain  = cur_reg.lf;
    assign zero_pos = cur_reg.zero;
    assign pole_pos = cur_reg.pole;
    assign hf_gain  = cur_reg.hf;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_light_set_used: assert property ( // [R07]
        @(posedge clk) disable iff (!resetn)
        light_mode |=> (lf_gain == $past(ll_lf)) && (hf_gain == $past(ll_hf))
                       && (zero_pos == $past(ll_zero)) && (pole_pos == $past(ll_pole)))
        else $error("light-load set not applied");

    a_normal_set_used: assert property ( // [R07]
        @(posedge clk) disable iff (!resetn)
        !light_mode |=> (lf_gain == $past(nrm_lf)) && (hf_gain == $past(nrm_hf))
                        && (zero_pos == $past(nrm_zero)) && (pole_pos == $past(nrm_pole)))
        else $error("normal set not applied");

endmodule : lfcb_coef_sel

// File: lfcb_regbank.sv
// apb register bank for the loop filter coefficients of two channels
// What this block does
// R01: channel B normal hf gain, 0.3 dB steps
// R02: per-channel light-load low-frequency gain, 0.3 dB steps
// R03: per-channel light-load zero, own setting
// R04: per-channel light-load pole, own setting
// R05: per-channel light-load hf gain, 0.3 dB steps
// R06: modulation limits for A then B
// R07: light-load set only while channel light-loaded
//
// Chosen here: the APB interface to the registers.
module lfcb_regbank (
    input  wire logic                 clk,
    input  wire logic                 resetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire lfcb_pkg::lfcb_addr_t paddr,
    input  wire lfcb_pkg::lfcb_word_t pwdata,
    input  wire logic [3:0]           pstrb,
    output lfcb_pkg::lfcb_word_t      prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 cha_light_mode,
    input  wire logic                 chb_light_mode,
    input  wire lfcb_pkg::lfcb_coef_t cha_nrm_lf_gain,
    input  wire lfcb_pkg::lfcb_coef_t cha_nrm_zero,
    input  wire lfcb_pkg::lfcb_coef_t cha_nrm_pole,
    input  wire lfcb_pkg::lfcb_coef_t cha_nrm_hf_gain,
    input  wire lfcb_pkg::lfcb_coef_t chb_nrm_lf_gain,
    input  wire lfcb_pkg::lfcb_coef_t chb_nrm_zero,
    input  wire lfcb_pkg::lfcb_coef_t chb_nrm_pole,
    output lfcb_pkg::lfcb_coef_t      cha_lf_gain,
    output lfcb_pkg::lfcb_coef_t      cha_zero,
    output lfcb_pkg::lfcb_coef_t      cha_pole,
    output lfcb_pkg::lfcb_coef_t      cha_hf_gain,
    output lfcb_pkg::lfcb_coef_t      chb_lf_gain,
    output lfcb_pkg::lfcb_coef_t      chb_zero,
    output lfcb_pkg::lfcb_coef_t      chb_pole,
    output lfcb_pkg::lfcb_coef_t      chb_hf_gain,
    output lfcb_pkg::lfcb_coef_t      cha_mod_limit,
    output lfcb_pkg::lfcb_coef_t      chb_mod_limit
);
    import lfcb_pkg::*;
    `include "lfcb_cfg.svh"

    // ----------------------------------------
    // state
    // ----------------------------------------
    lfcb_bank_t  cur_reg;
    lfcb_bank_t  cur_next;
    logic [15:0] idx;
    logic        aligned;
    logic        hit;
    lfcb_coef_t  rd_byte;

    assign idx     = paddr[`LFCB_IDX_MSB:`LFCB_IDX_LSB];
    assign aligned = (paddr[1:0] == 2'h0);

    // ----------------------------------------
    // address decode and read mux
    // ----------------------------------------
    always_comb begin
        hit     = aligned;
        rd_byte = 8'h00;
        case (idx)
            `LFCB_IDX_CHB_NRM_HF:  rd_byte = cur_reg.regs.chb_nrm_hf;
            `LFCB_IDX_CHA_LL_LF:   rd_byte = cur_reg.regs.cha_ll_lf;
            `LFCB_IDX_CHB_LL_LF:   rd_byte = cur_reg.regs.chb_ll_lf;
            `LFCB_IDX_CHA_LL_ZERO: rd_byte = cur_reg.regs.cha_ll_zero;
            `LFCB_IDX_CHB_LL_ZERO: rd_byte = cur_reg.regs.chb_ll_zero;
            `LFCB_IDX_CHA_LL_POLE: rd_byte = cur_reg.regs.cha_ll_pole;
            `LFCB_IDX_CHB_LL_POLE: rd_byte = cur_reg.regs.chb_ll_pole;
            `LFCB_IDX_CHA_LL_HF:   rd_byte = cur_reg.regs.cha_ll_hf;
            `LFCB_IDX_CHB_LL_HF:   rd_byte = cur_reg.regs.chb_ll_hf;
            `LFCB_IDX_CHA_MODLIM:  rd_byte = cur_reg.regs.cha_modlim;
            `LFCB_IDX_CHB_MODLIM:  rd_byte = cur_reg.regs.chb_modlim;
            default:               hit     = 1'b0;
        endcase
        if (!aligned) begin
            rd_byte = 8'h00;
        end
    end

    // ----------------------------------------
    // bus slave and register writes
    // ----------------------------------------
    // read data is captured in the setup cycle, so one access cycle
    // suffices and pready needs no wait state
    always_comb begin
        cur_next = cur_reg;
        case (cur_reg.st)
            LFCB_ST_IDLE: begin
                if (psel && !penable) begin
                    cur_next.st      = LFCB_ST_ACCESS;
                    cur_next.prdata  = {{`LFCB_RD_PAD_W{1'b0}}, rd_byte};
                    cur_next.pslverr = !hit;
                end
            end
            LFCB_ST_ACCESS: begin
                cur_next.st = LFCB_ST_IDLE;
                if (psel && penable && pwrite && hit && pstrb[0]) begin
                    case (idx)
                        `LFCB_IDX_CHB_NRM_HF:
                            cur_next.regs.chb_nrm_hf = pwdata[7:0]; // [R01]
                        `LFCB_IDX_CHA_LL_LF:
                            cur_next.regs.cha_ll_lf = pwdata[7:0]; // [R02]
                        `LFCB_IDX_CHB_LL_LF:
                            cur_next.regs.chb_ll_lf = pwdata[7:0]; // [R02]
                        `LFCB_IDX_CHA_LL_ZERO:
                            cur_next.regs.cha_ll_zero = pwdata[7:0]; // [R03]
                        `LFCB_IDX_CHB_LL_ZERO:
                            cur_next.regs.chb_ll_zero = pwdata[7:0]; // [R03]
                        `LFCB_IDX_CHA_LL_POLE:
                            cur_next.regs.cha_ll_pole = pwdata[7:0]; // [R04]
                        `LFCB_IDX_CHB_LL_POLE:
                            cur_next.regs.chb_ll_pole = pwdata[7:0]; // [R04]
                        `LFCB_IDX_CHA_LL_HF:
                            cur_next.regs.cha_ll_hf = pwdata[7:0]; // [R05]
                        `LFCB_IDX_CHB_LL_HF:
                            cur_next.regs.chb_ll_hf = pwdata[7:0]; // [R05]
                        `LFCB_IDX_CHA_MODLIM:
                            cur_next.regs.cha_modlim = pwdata[7:0]; // [R06]
                        `LFCB_IDX_CHB_MODLIM:
                            cur_next.regs.chb_modlim = pwdata[7:0]; // [R06]
                        default:
                            cur_next.regs = cur_reg.regs;
                    endcase
                end
            end
            default: begin
                cur_next.st = LFCB_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cur_reg.st      <= LFCB_ST_IDLE;
            cur_reg.regs    <= {{9{`LFCB_RST_COEF}}, {2{`LFCB_RST_MODLIM}}};
            cur_reg.prdata  <= `LFCB_RST_RDATA;
            cur_reg.pslverr <= 1'b0;
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign pready        = (cur_reg.st == LFCB_ST_ACCESS);
    assign prdata        = cur_reg.prdata;
    assign pslverr       = cur_reg.pslverr;
    assign cha_mod_limit = cur_reg.regs.cha_modlim; // [R06]
    assign chb_mod_limit = cur_reg.regs.chb_modlim; // [R06]

    // ----------------------------------------
    // per-channel coefficient selection
    // ----------------------------------------
    lfcb_coef_sel u_sel_a (
        .clk        (clk),
        .resetn     (resetn),
        .light_mode (cha_light_mode),
        .nrm_lf     (cha_nrm_lf_gain),
        .nrm_zero   (cha_nrm_zero),
        .nrm_pole   (cha_nrm_pole),
        .nrm_hf     (cha_nrm_hf_gain),
        .ll_lf      (cur_reg.regs.cha_ll_lf),
        .ll_zero    (cur_reg.regs.cha_ll_zero),
        .ll_pole    (cur_reg.regs.cha_ll_pole),
        .ll_hf      (cur_reg.regs.cha_ll_hf),
        .lf_gain    (cha_lf_gain),
        .zero_pos   (cha_zero),
        .pole_pos   (cha_pole),
        .hf_gain    (cha_hf_gain)
    );

    // channel B normal hf gain lives here, the rest of its normal set does not
    lfcb_coef_sel u_sel_b (
        .clk        (clk),
        .resetn     (resetn),
        .light_mode (chb_light_mode),
        .nrm_lf     (chb_nrm_lf_gain),
        .nrm_zero   (chb_nrm_zero),
        .nrm_pole   (chb_nrm_pole),
        .nrm_hf     (cur_reg.regs.chb_nrm_hf), // [R01]
        .ll_lf      (cur_reg.regs.chb_ll_lf),
        .ll_zero    (cur_reg.regs.chb_ll_zero),
        .ll_pole    (cur_reg.regs.chb_ll_pole),
        .ll_hf      (cur_reg.regs.chb_ll_hf),
        .lf_gain    (chb_lf_gain),
        .zero_pos   (chb_zero),
        .pole_pos   (chb_pole),
        .hf_gain    (chb_hf_gain)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence s_setup_wr(logic [15:0] i);
        psel && !penable && pwrite && pstrb[0] && (paddr[1:0] == 2'h0)
        && (paddr[`LFCB_IDX_MSB:`LFCB_IDX_LSB] == i);
    endsequence

    sequence s_access;
        psel && penable && pready;
    endsequence

    a_chb_hf_write: assert property ( // [R01]
        s_setup_wr(`LFCB_IDX_CHB_NRM_HF) ##1 s_access
        |=> (cur_reg.regs.chb_nrm_hf == $past(pwdata[7:0]))
        ##2 ($past(chb_light_mode) || chb_hf_gain == $past(cur_reg.regs.chb_nrm_hf, 1)))
        else $error("channel B normal hf gain not taken");

    a_cha_lf_write: assert property ( // [R02]
        s_setup_wr(`LFCB_IDX_CHA_LL_LF) ##1 s_access
        |=> cur_reg.regs.cha_ll_lf == $past(pwdata[7:0]))
        else $error("channel A light-load lf gain not taken");

    a_chb_zero_wr: assert property ( // [R03]
        s_setup_wr(`LFCB_IDX_CHB_LL_ZERO) ##1 s_access
        |=> (cur_reg.regs.chb_ll_zero == $past(pwdata[7:0]))
            && $stable(cur_reg.regs.cha_ll_zero))
        else $error("channel B light-load zero not taken");

    a_cha_pole_wr: assert property ( // [R04]
        s_setup_wr(`LFCB_IDX_CHA_LL_POLE) ##1 s_access
        |=> (cur_reg.regs.cha_ll_pole == $past(pwdata[7:0]))
            && $stable(cur_reg.regs.chb_ll_pole))
        else $error("channel A light-load pole not taken");

    a_chb_hf_light: assert property ( // [R05]
        s_setup_wr(`LFCB_IDX_CHB_LL_HF) ##1 s_access ##1 chb_light_mode [*2]
        |=> chb_hf_gain == $past(pwdata[7:0], 3))
        else $error("channel B light-load hf gain not applied");

    a_modlim_out: assert property ( // [R06]
        s_setup_wr(`LFCB_IDX_CHA_MODLIM) ##1 s_access
        |=> (cha_mod_limit == $past(pwdata[7:0])) && $stable(chb_mod_limit))
        else $error("modulation limit write misrouted");

    a_ready_after_setup: assert property (
        psel && !penable |=> pready)
        else $error("no ready in access cycle");

    a_unmapped_error: assert property (
        psel && !penable && !hit |=> pslverr && (prdata == 32'h0000_0000))
        else $error("unmapped access not flagged");

    a_read_returns: assert property (
        psel && !penable && !pwrite && hit |=> prdata[7:0] == $past(rd_byte))
        else $error("read data mismatch");

    a_chb_lf_write: assert property ( // [R02]
        s_setup_wr(`LFCB_IDX_CHB_LL_LF) ##1 s_access
        |=> cur_reg.regs.chb_ll_lf == $past(pwdata[7:0]))
        else $error("channel B light-load lf gain not taken");

    a_cha_zero_wr: assert property ( // [R03]
        s_setup_wr(`LFCB_IDX_CHA_LL_ZERO) ##1 s_access
        |=> (cur_reg.regs.cha_ll_zero == $past(pwdata[7:0]))
            && $stable(cur_reg.regs.chb_ll_zero))
        else $error("channel A light-load zero not taken");

    a_chb_pole_wr: assert property ( // [R04]
        s_setup_wr(`LFCB_IDX_CHB_LL_POLE) ##1 s_access
        |=> (cur_reg.regs.chb_ll_pole == $past(pwdata[7:0]))
            && $stable(cur_reg.regs.cha_ll_pole))
        else $error("channel B light-load pole not taken");

    a_cha_hf_write: assert property ( // [R05]
        s_setup_wr(`LFCB_IDX_CHA_LL_HF) ##1 s_access
        |=> cur_reg.regs.cha_ll_hf == $past(pwdata[7:0]))
        else $error("channel A light-load hf gain not taken");

    a_chb_llhf_write: assert property ( // [R05]
        s_setup_wr(`LFCB_IDX_CHB_LL_HF) ##1 s_access
        |=> cur_reg.regs.chb_ll_hf == $past(pwdata[7:0]))
        else $error("channel B light-load hf gain not taken");

    a_chb_modlim_out: assert property ( // [R06]
        s_setup_wr(`LFCB_IDX_CHB_MODLIM) ##1 s_access
        |=> (chb_mod_limit == $past(pwdata[7:0])) && $stable(cha_mod_limit))
        else $error("channel B modulation limit misrouted");

    a_chb_hf_route: assert property ( // [R01]
        !chb_light_mode |=> chb_hf_gain == $past(cur_reg.regs.chb_nrm_hf))
        else $error("channel B normal hf gain not routed");

    // limits move only on a bus write, never on their own
    a_modlim_steady: assert property ( // [R06]
        !(psel && penable && pwrite) |=> $stable(cha_mod_limit) && $stable(chb_mod_limit))
        else $error("modulation limit changed without write");

    a_strobe_gates_wr: assert property (
        psel && !penable && pwrite && !pstrb[0] ##1 s_access |=> $stable(cur_reg.regs))
        else $error("write without low strobe changed bank");

    a_refused_no_wr: assert property (
        psel && !penable && pwrite && !hit ##1 s_access |=> $stable(cur_reg.regs))
        else $error("refused write changed bank");

    a_ready_one_cycle: assert property (
        pready |=> !pready)
        else $error("ready held past access cycle");

    a_idle_no_ready: assert property (
        !psel |=> !pready)
        else $error("ready without select");

    a_mapped_no_error: assert property (
        psel && !penable && hit |=> !pslverr)
        else $error("mapped access flagged as error");

endmodule : lfcb_regbank

// File: lfcb_tb.sv
// self-checking testbench of the loop filter coefficient bank
`include "lfcb_cfg.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import lfcb_pkg::*;

    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic       clk;
    logic       resetn;
    logic       psel;
    logic       penable;
    logic       pwrite;
    lfcb_addr_t paddr;
    lfcb_word_t pwdata;
    logic [3:0] pstrb;
    lfcb_word_t prdata;
    logic       pready;
    logic       pslverr;
    logic       cha_light_mode;
    logic       chb_light_mode;
    lfcb_coef_t cha_nrm_lf_gain;
    lfcb_coef_t cha_nrm_zero;
    lfcb_coef_t cha_nrm_pole;
    lfcb_coef_t cha_nrm_hf_gain;
    lfcb_coef_t chb_nrm_lf_gain;
    lfcb_coef_t chb_nrm_zero;
    lfcb_coef_t chb_nrm_pole;
    lfcb_coef_t cha_lf_gain;
    lfcb_coef_t cha_zero;
    lfcb_coef_t cha_pole;
    lfcb_coef_t cha_hf_gain;
    lfcb_coef_t chb_lf_gain;
    lfcb_coef_t chb_zero;
    lfcb_coef_t chb_pole;
    lfcb_coef_t chb_hf_gain;
    lfcb_coef_t cha_mod_limit;
    lfcb_coef_t chb_mod_limit;
    int         errors;
    int         num_checks;
    lfcb_word_t rd;
    logic       err;
    logic [15:0] idx_tab [11] = '{`LFCB_IDX_CHB_NRM_HF, `LFCB_IDX_CHA_LL_LF,
        `LFCB_IDX_CHB_LL_LF, `LFCB_IDX_CHA_LL_ZERO, `LFCB_IDX_CHB_LL_ZERO,
        `LFCB_IDX_CHA_LL_POLE, `LFCB_IDX_CHB_LL_POLE, `LFCB_IDX_CHA_LL_HF,
        `LFCB_IDX_CHB_LL_HF, `LFCB_IDX_CHA_MODLIM, `LFCB_IDX_CHB_MODLIM};

    lfcb_regbank i_dut (
        .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cha_light_mode(cha_light_mode),
        .chb_light_mode(chb_light_mode), .cha_nrm_lf_gain(cha_nrm_lf_gain),
        .cha_nrm_zero(cha_nrm_zero), .cha_nrm_pole(cha_nrm_pole),
        .cha_nrm_hf_gain(cha_nrm_hf_gain), .chb_nrm_lf_gain(chb_nrm_lf_gain),
        .chb_nrm_zero(chb_nrm_zero), .chb_nrm_pole(chb_nrm_pole),
        .cha_lf_gain(cha_lf_gain), .cha_zero(cha_zero), .cha_pole(cha_pole),
        .cha_hf_gain(cha_hf_gain), .chb_lf_gain(chb_lf_gain), .chb_zero(chb_zero),
        .chb_pole(chb_pole), .chb_hf_gain(chb_hf_gain),
        .cha_mod_limit(cha_mod_limit), .chb_mod_limit(chb_mod_limit)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic lfcb_addr_t baddr(input logic [15:0] ix);
        return {ix, 2'b00};
    endfunction : baddr

    // distinct per register, first one near full scale
    function automatic lfcb_coef_t wval(input logic [7:0] i);
        return 8'hF0 - 8'h0F * i;
    endfunction : wval

    task automatic chk(input lfcb_word_t got, input lfcb_word_t exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; starts one edge on so psel never changes twice in a step
    task automatic bus(input lfcb_addr_t a, input logic w, input lfcb_word_t wd,
                       input logic [3:0] s);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        pstrb   <= s;
        @(posedge clk);
        penable <= 1'b1;
        // no wait limit here: the watchdog ends a hung transfer
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : bus

    task automatic do_reset;
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
    endtask : do_reset

    // outputs are registered, up to two edges behind their cause
    task automatic settle;
        repeat (3) @(posedge clk);
    endtask : settle

    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    // ----------------------------------------
    // watchdog
    // ----------------------------------------
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        wrap_up;
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        errors = 0;
        num_checks = 0;
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'h0;
        cha_light_mode = 1'b0;
        chb_light_mode = 1'b0;
        {cha_nrm_lf_gain, cha_nrm_zero, cha_nrm_pole, cha_nrm_hf_gain} = 32'h2122_2324;
        {chb_nrm_lf_gain, chb_nrm_zero, chb_nrm_pole} = 24'h31_3233;
        do_reset;
        for (int i = 0; i < 11; i++) begin
            bus(baddr(idx_tab[i]), 1'b0, 32'h0, 4'h0);
            chk(rd, 32'h0);
            chk({31'h0, err}, 32'h0);
        end
        // upper data bits set on purpose: only the low byte may stick
        for (int i = 0; i < 11; i++) begin
            bus(baddr(idx_tab[i]), 1'b1, {24'hFFFFFF, wval(i[7:0])}, 4'hF);
        end
        for (int i = 0; i < 11; i++) begin
            bus(baddr(idx_tab[i]), 1'b0, 32'h0, 4'h0);
            chk(rd, {24'h0, wval(i[7:0])});
        end
        settle;
        chk({cha_lf_gain, cha_zero, cha_pole, cha_hf_gain}, 32'h2122_2324);
        chk({chb_lf_gain, chb_zero, chb_pole, chb_hf_gain},
            {24'h31_3233, wval(0)});
        chk({16'h0, cha_mod_limit, chb_mod_limit}, {16'h0, wval(9), wval(10)});
        cha_light_mode <= 1'b1;
        settle;
        chk({cha_lf_gain, cha_zero, cha_pole, cha_hf_gain},
            {wval(1), wval(3), wval(5), wval(7)});
        chk({chb_lf_gain, chb_zero, chb_pole, chb_hf_gain},
            {24'h31_3233, wval(0)});
        // normal settings move while light-load holds its own
        cha_nrm_zero <= 8'h5C;
        cha_nrm_pole <= 8'h3C;
        settle;
        chk({cha_lf_gain, cha_zero, cha_pole, cha_hf_gain},
            {wval(1), wval(3), wval(5), wval(7)});
        cha_light_mode <= 1'b0;
        chb_light_mode <= 1'b1;
        settle;
        chk({cha_lf_gain, cha_zero, cha_pole, cha_hf_gain}, 32'h215C_3C24);
        chk({chb_lf_gain, chb_zero, chb_pole, chb_hf_gain},
            {wval(2), wval(4), wval(6), wval(8)});
        // light-load hf gain rewritten while in use
        bus(baddr(`LFCB_IDX_CHB_LL_HF), 1'b1, 32'h4B, 4'h1);
        settle;
        chk({24'h0, chb_hf_gain}, 32'h4B);
        // refused and ignored accesses leave the bank alone
        bus(baddr(16'hFE3E), 1'b1, 32'h77, 4'hF);
        chk({31'h0, err}, 32'h1);
        bus(baddr(16'hFE32), 1'b0, 32'h0, 4'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        bus({`LFCB_IDX_CHA_LL_LF, 2'b01}, 1'b1, 32'h77, 4'hF);
        chk({31'h0, err}, 32'h1);
        bus(baddr(`LFCB_IDX_CHA_LL_LF), 1'b1, 32'h66, 4'hE);
        chk({31'h0, err}, 32'h0);
        bus(baddr(`LFCB_IDX_CHA_LL_LF), 1'b0, 32'h0, 4'h0);
        chk(rd, {24'h0, wval(1)});
        // second reset in mid-run clears the bank
        do_reset;
        settle;
        chk({16'h0, cha_mod_limit, chb_mod_limit}, 32'h0);
        bus(baddr(`LFCB_IDX_CHB_LL_HF), 1'b0, 32'h0, 4'h0);
        chk(rd, 32'h0);
        wrap_up;
    end

endmodule : testbench
